/* File: design/dram_mode_ctrl.sv */
// Function
// - mr1 a0 high disables dll until cleared
// - clock ignored once sref entry delay passes
// - slow and fast powerdown exits alike
// - strobe rising edge samples clock, fed back
// - feedback returned separately per byte lane
// - mr1 a7 enters and leaves leveling
// - dll-off mode flags latencies other than six
module dram_mode_ctrl
    import dram_mode_pkg::*;
#(
    parameter int         ADDR_W   = 16,
    parameter int         LANE_W   = 8,
    parameter logic [3:0] CL6_CODE  = 4'h4,
    parameter logic [2:0] CWL6_CODE = 3'h1
) (
    input  wire logic                ref_clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                cs_n_in,
    input  wire logic                ras_n_in,
    input  wire logic                cas_n_in,
    input  wire logic                we_n_in,
    input  wire logic                cke_in,
    input  wire logic [2:0]          ba_in,
    input  wire logic [ADDR_W-1:0]   addr_in,
    input  wire logic                ck_level_in,
    input  wire logic                upper_lane_strobe_pair_in,
    input  wire logic                lower_lane_strobe_pair_in,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    output logic [2*LANE_W-1:0]      dq_out,
    output logic [2*LANE_W-1:0]      dq_oe_n_out,
    output logic                     dll_off_out,
    output logic                     dll_locked_out,
    output logic                     wl_active_out,
    output logic                     clk_ignored_out
);
    typedef struct packed {
        pwr_state_e  state;
        logic        cke_prev;
        logic        dll_off;
        logic        dll_locked;
        logic        wl_active;
        logic        clk_ignored;
        logic [3:0]  cl_code;
        logic [2:0]  cwl_code;
        logic [15:0] sre_cnt;
        logic [15:0] lock_cnt;
        logic        fb_en;
        logic [15:0] lock_cycles;
        logic [15:0] sre_cycles;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } ctrl_s;

    ctrl_s ctrl_reg;
    ctrl_s ctrl_next;

    logic        is_mrs;
    logic        is_refresh;
    logic        is_nop;
    logic        latency_ok;
    logic        apb_setup;
    logic        apb_commit;
    logic        level_active;
    logic [31:0] status_word;

    assign is_mrs     = !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;
    assign is_refresh = !cs_n_in && !ras_n_in && !cas_n_in && we_n_in;
    assign is_nop     = cs_n_in || (ras_n_in && cas_n_in && we_n_in);
    // only cl 6 and cwl 6 are honoured with the dll off
    assign latency_ok = !ctrl_reg.dll_off
                        || (ctrl_reg.cl_code == CL6_CODE && ctrl_reg.cwl_code == CWL6_CODE);
    assign apb_setup  = psel && penable && !ctrl_reg.pready;
    assign apb_commit = psel && penable && ctrl_reg.pready;
    assign level_active = ctrl_reg.wl_active && ctrl_reg.fb_en;

    always_comb begin
        status_word = '0;
        status_word[ST_DLL_OFF_BIT] = ctrl_reg.dll_off;
        status_word[ST_WL_BIT]      = ctrl_reg.wl_active;
        status_word[ST_LOCKED_BIT]  = ctrl_reg.dll_locked;
        status_word[ST_CLK_IGN_BIT] = ctrl_reg.clk_ignored;
        status_word[ST_LAT_OK_BIT]  = latency_ok;
        status_word[ST_STATE_LSB +: 3] = ctrl_reg.state;
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next.cke_prev = cke_in;

        // mode register writes, only taken with cke high outside low power states
        if (is_mrs && cke_in && ctrl_reg.state == ST_IDLE) begin
            case (ba_in)
                MR0_SEL: begin
                    ctrl_next.cl_code = {addr_in[CL_HI_LSB +: 3], addr_in[CL_LOW_BIT]};
                    if (addr_in[DLL_RESET_BIT] && !ctrl_reg.dll_off) begin
                        ctrl_next.dll_locked = 1'b0;
                        ctrl_next.lock_cnt   = ctrl_reg.lock_cycles;
                    end
                end
                MR1_SEL: begin
                    ctrl_next.dll_off   = addr_in[DLL_OFF_BIT];
                    ctrl_next.wl_active = addr_in[WL_EN_BIT];
                    if (addr_in[DLL_OFF_BIT]) begin
                        ctrl_next.dll_locked = 1'b0;
                        ctrl_next.lock_cnt   = '0;
                    end
                end
                MR2_SEL: begin
                    ctrl_next.cwl_code = addr_in[CWL_LSB +: 3];
                end
                default: begin
                    ctrl_next.cl_code = ctrl_reg.cl_code;
                end
            endcase
        end else if (ctrl_reg.lock_cnt != '0) begin
            ctrl_next.lock_cnt = ctrl_reg.lock_cnt - 16'h0001;
            if (ctrl_reg.lock_cnt == 16'h0001) begin
                ctrl_next.dll_locked = 1'b1;
            end
        end

        case (ctrl_reg.state)
            ST_IDLE: begin
                ctrl_next.clk_ignored = 1'b0;
                if (ctrl_reg.cke_prev && !cke_in) begin
                    ctrl_next.sre_cnt = ctrl_reg.sre_cycles;
                    if (is_refresh) begin
                        ctrl_next.state = ST_SREF;
                    end else if (is_nop) begin
                        ctrl_next.state = ST_PDOWN;
                    end
                end
            end
            // slow and fast exit powerdown share this path
            ST_SREF, ST_PDOWN: begin
                if (cke_in) begin
                    ctrl_next.state       = ST_IDLE;
                    ctrl_next.clk_ignored = 1'b0;
                end else if (ctrl_reg.sre_cnt != '0) begin
                    ctrl_next.sre_cnt = ctrl_reg.sre_cnt - 16'h0001;
                end else begin
                    ctrl_next.clk_ignored = 1'b1;
                end
            end
            default: begin
                ctrl_next.state = ST_IDLE;
            end
        endcase

        // apb slave: one wait state, write commits at the pready edge
        ctrl_next.pready = apb_setup;
        if (apb_setup) begin
            ctrl_next.prdata  = '0;
            ctrl_next.pslverr = 1'b0;
            case (paddr)
                CTRL_OFS:   ctrl_next.prdata[FB_EN_BIT] = ctrl_reg.fb_en;
                STATUS_OFS: ctrl_next.prdata = status_word;
                LOCK_OFS:   ctrl_next.prdata[15:0] = ctrl_reg.lock_cycles;
                SRE_OFS:    ctrl_next.prdata[15:0] = ctrl_reg.sre_cycles;
                default:    ctrl_next.pslverr = 1'b1;
            endcase
            if (pwrite) begin
                ctrl_next.prdata = '0;
            end
        end else if (!psel) begin
            ctrl_next.pslverr = 1'b0;
        end
        if (apb_commit && pwrite) begin
            case (paddr)
                CTRL_OFS: ctrl_next.fb_en = pwdata[FB_EN_BIT];
                LOCK_OFS: ctrl_next.lock_cycles = pwdata[15:0];
                SRE_OFS:  ctrl_next.sre_cycles = pwdata[15:0];
                default:  ctrl_next.fb_en = ctrl_reg.fb_en;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ctrl_reg             <= '0;
            ctrl_reg.state       <= ST_IDLE;
            ctrl_reg.fb_en       <= FB_EN_RST;
            ctrl_reg.lock_cycles <= LOCK_CYCLES_RST;
            ctrl_reg.sre_cycles  <= SRE_CYCLES_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // separate feedback per byte lane
    lane_feedback #(.WIDTH(LANE_W)) u_lower_lane (
        .ref_clk_in      (ref_clk_in),
        .sys_rst_in      (sys_rst_in),
        .strobe_in       (lower_lane_strobe_pair_in),
        .ck_level_in     (ck_level_in),
        .level_active_in (level_active),
        .dq_out          (dq_out[LANE_W-1:0]),
        .dq_oe_n_out     (dq_oe_n_out[LANE_W-1:0])
    );

    lane_feedback #(.WIDTH(LANE_W)) u_upper_lane (
        .ref_clk_in      (ref_clk_in),
        .sys_rst_in      (sys_rst_in),
        .strobe_in       (upper_lane_strobe_pair_in),
        .ck_level_in     (ck_level_in),
        .level_active_in (level_active),
        .dq_out          (dq_out[2*LANE_W-1:LANE_W]),
        .dq_oe_n_out     (dq_oe_n_out[2*LANE_W-1:LANE_W])
    );

    assign pready          = ctrl_reg.pready;
    assign prdata          = ctrl_reg.prdata;
    assign pslverr         = ctrl_reg.pslverr;
    assign dll_off_out     = ctrl_reg.dll_off;
    assign dll_locked_out  = ctrl_reg.dll_locked;
    assign wl_active_out   = ctrl_reg.wl_active;
    assign clk_ignored_out = ctrl_reg.clk_ignored;

    a_dll_off_take: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        is_mrs && cke_in && ctrl_reg.state == ST_IDLE && ba_in == MR1_SEL
        |=> dll_off_out == $past(addr_in[DLL_OFF_BIT]))
        else $error("dll off bit not taken from mr1 write");

    a_dll_off_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !(is_mrs && ba_in == MR1_SEL) |=> $stable(dll_off_out))
        else $error("dll off changed without mr1 write");

    a_dll_off_unlock: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        dll_off_out |-> !dll_locked_out)
        else $error("dll reported locked while disabled");

    a_wl_mode_take: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        is_mrs && cke_in && ctrl_reg.state == ST_IDLE && ba_in == MR1_SEL
        |=> wl_active_out == $past(addr_in[WL_EN_BIT]))
        else $error("leveling mode not taken from mr1 write");

    a_clk_ign_delay: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        ctrl_reg.state == ST_IDLE && ctrl_reg.cke_prev && !cke_in && is_refresh
        && ctrl_reg.sre_cycles == 16'h0002
        ##1 !cke_in [*3] |=> clk_ignored_out)
        else $error("clock not ignored after entry delay");

    a_clk_ign_lowpwr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_ignored_out |-> ctrl_reg.state != ST_IDLE)
        else $error("clock ignored outside low power state");

    a_pd_exit_idle: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        ctrl_reg.state == ST_PDOWN && cke_in |=> ctrl_reg.state == ST_IDLE && !clk_ignored_out)
        else $error("powerdown exit not handled");

    a_lat_flag: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        ctrl_reg.dll_off && ctrl_reg.cl_code != CL6_CODE |-> !status_word[ST_LAT_OK_BIT])
        else $error("latency flag wrong in dll off mode");

    // mode writes in self refresh or powerdown must leave the flags alone
    a_mrs_lowpwr_ign: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        is_mrs && ctrl_reg.state != ST_IDLE
        |=> $stable(dll_off_out) && $stable(wl_active_out))
        else $error("mode write taken in low power state");

    a_fb_oe_idle: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !level_active |=> dq_oe_n_out == '1)
        else $error("dq driven outside leveling");
endmodule

/* File: design/dram_mode_pkg.sv */
package dram_mode_pkg;

    // mode register select on bank address
    localparam logic [2:0] MR0_SEL = 3'h0;
    localparam logic [2:0] MR1_SEL = 3'h1;
    localparam logic [2:0] MR2_SEL = 3'h2;

    // mode register bit positions
    localparam int DLL_OFF_BIT   = 0;
    localparam int WL_EN_BIT     = 7;
    localparam int DLL_RESET_BIT = 8;
    localparam int CL_LOW_BIT    = 2;
    localparam int CL_HI_LSB     = 4;
    localparam int CWL_LSB       = 3;

    // apb register byte offsets
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] LOCK_OFS   = 12'h008;
    localparam logic [11:0] SRE_OFS    = 12'h00c;

    // ctrl field positions and reset values
    localparam int FB_EN_BIT = 0;
    localparam logic        FB_EN_RST       = 1'h1;
    localparam logic [15:0] LOCK_CYCLES_RST = 16'h0200;
    localparam logic [15:0] SRE_CYCLES_RST  = 16'h000a;

    // status field positions
    localparam int ST_DLL_OFF_BIT = 0;
    localparam int ST_WL_BIT      = 1;
    localparam int ST_LOCKED_BIT  = 2;
    localparam int ST_CLK_IGN_BIT = 3;
    localparam int ST_LAT_OK_BIT  = 4;
    localparam int ST_STATE_LSB   = 8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SREF  = 3'b010,
        ST_PDOWN = 3'b100
    } pwr_state_e;

endpackage

/* File: design/lane_feedback.sv */
module lane_feedback #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             strobe_in,
    input  wire logic             ck_level_in,
    input  wire logic             level_active_in,
    output logic [WIDTH-1:0]      dq_out,
    output logic [WIDTH-1:0]      dq_oe_n_out
);
    typedef struct packed {
        logic strobe_prev;
        logic sample;
        logic drive;
    } lane_s;

    lane_s lane_reg;
    lane_s lane_next;

    always_comb begin
        lane_next = lane_reg;
        lane_next.strobe_prev = strobe_in;
        lane_next.drive = level_active_in;
        // ck sampled on each rising strobe edge while level_active_in is high
        if (level_active_in && strobe_in && !lane_reg.strobe_prev) begin
            lane_next.sample = ck_level_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            lane_reg <= '0;
        end else begin
            lane_reg <= lane_next;
        end
    end

    // every bit of the lane carries the lane's own sample
    assign dq_out      = {WIDTH{lane_reg.sample}};
    assign dq_oe_n_out = {WIDTH{~lane_reg.drive}};

    a_fb_sample_edge: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        level_active_in && strobe_in && !lane_reg.strobe_prev
        |=> lane_reg.sample == $past(ck_level_in))
        else $error("feedback did not take ck level at strobe edge");

    a_fb_hold_between: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !(strobe_in && !lane_reg.strobe_prev) |=> $stable(lane_reg.sample))
        else $error("feedback changed without a strobe edge");

    a_lane_drive_en: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        level_active_in |=> dq_oe_n_out == '0 ##1 1'b1)
        else $error("lane not driven during leveling");
endmodule

/* File: tb/ctrl_model.sv */
module ctrl_model (
    input  wire logic        clk_in,
    output logic             cs_n_out,
    output logic             ras_n_out,
    output logic             cas_n_out,
    output logic             we_n_out,
    output logic             cke_out,
    output logic [2:0]       ba_out,
    output logic [15:0]      addr_out,
    output logic             ck_out,
    output logic             ustb_out,
    output logic             lstb_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hold;
    logic ck_v;
    initial begin
        {cs_n_out, ras_n_out, cas_n_out, we_n_out, cke_out} = 5'h1f;
        {ba_out, addr_out, ck_out, ustb_out, lstb_out, hold, ck_v} = '0;
    end
    // ck runs free except while a strobe pulse pins its level
    always @(posedge clk_in) begin
        ck_out <= hold ? ck_v : ~ck_out;
    end
    // one command, then nop with the address lines turned over
    task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                       input logic [15:0] a, input logic k);
        @(posedge clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= c;
        ba_out <= b;
        addr_out <= a;
        cke_out <= k;
        @(posedge clk_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h7;
        addr_out <= ~a;
    endtask
    // strobe low, then high on chosen lanes with ck held at v
    task automatic pulse(input logic up, input logic lo, input logic v);
        @(posedge clk_in);
        hold <= 1'b1;
        ck_v <= v;
        {ustb_out, lstb_out} <= 2'h0;
        @(posedge clk_in);
        {ustb_out, lstb_out} <= {up, lo};
        repeat (2) @(posedge clk_in);
        {ustb_out, lstb_out, hold} <= 3'h0;
    endtask
endmodule

/* File: tb/dram_dll_switch_freq_change_leveling_tb.sv */
module dram_dll_switch_freq_change_leveling_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dram_mode_pkg::*;
    localparam logic [3:0] CL6  = 4'h4;
    localparam logic [2:0] CWL6 = 3'h1;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        cs_n, ras_n, cas_n, we_n, cke, ck, us, ls;
    logic        dll_off, locked, wl, ign;
    logic [2:0]  ba;
    logic [3:0]  c;
    logic [11:0] paddr;
    logic [15:0] addr, dq, oe_n;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [31:0] exp_rst [4];
    int          mismatches, total_checks, cyc, n;

    ctrl_model m (.clk_in(clk), .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n),
        .we_n_out(we_n), .cke_out(cke), .ba_out(ba), .addr_out(addr), .ck_out(ck),
        .ustb_out(us), .lstb_out(ls));
    dram_mode_ctrl #(.CL6_CODE(CL6), .CWL6_CODE(CWL6)) uut (.ref_clk_in(clk),
        .sys_rst_in(rst), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n),
        .we_n_in(we_n), .cke_in(cke), .ba_in(ba), .addr_in(addr), .ck_level_in(ck),
        .upper_lane_strobe_pair_in(us), .lower_lane_strobe_pair_in(ls), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .dq_out(dq),
        .dq_oe_n_out(oe_n), .dll_off_out(dll_off), .dll_locked_out(locked),
        .wl_active_out(wl), .clk_ignored_out(ign));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] stat(input logic d, w, k, i, l, input logic [2:0] s);
        return {21'h0, s, 3'h0, l, i, k, w, d};
    endfunction
    function automatic logic [15:0] mr0(input logic [3:0] cl, input logic r);
        return {7'h0, r, 1'b0, cl[3:1], 1'b0, cl[0], 2'h0};
    endfunction
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", 1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic st(input logic [31:0] e);
        apb(0, STATUS_OFS, 0);
        check("status", e, rd);
        check("pins", {28'h0, e[3:0]}, {28'h0, ign, locked, wl, dll_off});
    endtask
    // lk selects the lock flag, otherwise the clock-ignored flag
    task automatic wait_flag(input logic lk, input int lo, input int hi);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((lk ? locked : ign) !== 1'b1 && n < 40);
        check("wait", 1, 32'(n >= lo && n <= hi));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {mismatches, total_checks, cyc, seed} = {96'h0, 32'd95838};
        exp_rst = '{{31'h0, FB_EN_RST}, stat(0, 0, 0, 0, 1, ST_IDLE),
                    {16'h0, LOCK_CYCLES_RST}, {16'h0, SRE_CYCLES_RST}};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(0, 12'(i * 4), 0);
            check("reset", exp_rst[i], rd);
        end
        apb(1, 12'h010, 32'hffff_ffff);
        check("slverr", 1, {31'h0, err});
        apb(1, LOCK_OFS, 32'h4);
        apb(1, SRE_OFS, 32'h2);
        apb(0, SRE_OFS, 0);
        check("sre", 32'h2, rd);
        $display("end registers");
        seed = lfsr(seed);
        c = seed[3:0] ^ {3'h0, seed[3:0] == CL6};
        m.cmd(4'h0, MR2_SEL, {10'h0, CWL6, 3'h0}, 1);
        m.cmd(4'h0, MR0_SEL, mr0(c, 0), 1);
        m.cmd(4'h0, MR1_SEL, 16'h0001, 1);
        st(stat(1, 0, 0, 0, 0, ST_IDLE));
        m.cmd(4'h0, MR0_SEL, mr0(CL6, 0), 1);
        st(stat(1, 0, 0, 0, 1, ST_IDLE));
        $display("end dll off");
        m.cmd(4'h1, 3'h0, 16'h0, 0);
        wait_flag(0, 2, 5);
        st(stat(1, 0, 0, 1, 1, ST_SREF));
        m.cmd(4'h0, MR1_SEL, 16'h0, 0);
        m.cmd(4'h7, 3'h0, 16'h0, 1);
        st(stat(1, 0, 0, 0, 1, ST_IDLE));
        $display("end self refresh");
        m.cmd(4'h0, MR1_SEL, 16'h0, 1);
        for (int k = 0; k < 2; k++) begin
            m.cmd(4'h0, MR0_SEL, mr0(CL6, 1), 1);
            m.cmd(4'h6, 3'h0, 16'h0400, 1);
            wait_flag(1, 2, 7);
        end
        st(stat(0, 0, 1, 0, 1, ST_IDLE));
        m.cmd(4'h7, 3'h0, 16'h0, 0);
        wait_flag(0, 0, 5);
        st(stat(0, 0, 1, 1, 1, ST_PDOWN));
        m.cmd(4'h7, 3'h0, 16'h0, 1);
        st(stat(0, 0, 1, 0, 1, ST_IDLE));
        $display("end dll on and power down");
        m.cmd(4'h0, MR1_SEL, 16'h0080, 1);
        repeat (2) @(posedge clk);
        check("oe_n", 0, {16'h0, oe_n});
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            m.pulse(1, 1, seed[0]);
            m.pulse(0, 1, ~seed[0]);
            repeat (2) @(posedge clk);
            check("dq", {16'h0, {8{seed[0]}}, {8{~seed[0]}}}, {16'h0, dq});
        end
        st(stat(0, 1, 1, 0, 1, ST_IDLE));
        apb(1, CTRL_OFS, 0);
        repeat (2) @(posedge clk);
        check("oe_n", 32'hffff, {16'h0, oe_n});
        apb(1, CTRL_OFS, 1);
        m.cmd(4'h0, MR1_SEL, 16'h0, 1);
        repeat (2) @(posedge clk);
        check("oe_n", 32'hffff, {16'h0, oe_n});
        st(stat(0, 0, 1, 0, 1, ST_IDLE));
        $display("end leveling");
        conclude();
    end
endmodule
